// *** hw/aoc_top.sv ***
`default_nettype none
module aoc_top
   import aoc_pkg::*;
#(
   parameter logic [26:0] PH1_CYC = 27'(PH1_CYC_D),
   parameter logic [26:0] PH2_CYC = 27'(PH2_CYC_D),
   parameter logic [26:0] MON_CYC = 27'(MON_CYC_D),
   parameter logic [26:0] SLEW_CYC = 27'(SLEW_CYC_D)
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic signed [25:0] sample_in,
   input wire logic sample_valid,
   input wire logic pdcm_cmd,
   output logic [15:0] pdcm_word,
   output logic pdcm_valid,
   output logic offset_error,
   output logic offset_init_done
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic aoc_mapped(input logic [7:0] a);
      return a == A_CFG || a == A_ACCEL_STAT || a == A_DEV_STAT ||
         a == A_DATA_HI || a == A_DATA_LO || a == A_OFF_LIM ||
         a == A_CNT_LIM;
   endfunction : aoc_mapped

   // same LSB weight for every width, only the range differs
   function automatic logic [15:0] aoc_clip(
      input logic signed [32:0] v,
      input logic [1:0] w);
      logic signed [32:0] s;
      logic signed [32:0] m;
      s = v >>> SCALE_SH;
      case (w)
         2'h0: m = MAX10;
         2'h1: m = MAX14;
         default: m = MAX16;
      endcase
      if (s > m)
         return m[15:0];
      else if (s < -m)
         return 16'(-m);
      else
         return s[15:0];
   endfunction : aoc_clip

   function automatic logic [31:0] aoc_merge(
      input logic [31:0] o,
      input logic [31:0] d,
      input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction : aoc_merge

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic aw_got, w_got, wr_en;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic [4:0] cfg;
   logic [25:0] off_lim;
   logic [7:0] cnt_lim;
   logic [15:0] data16;
   aoc_phase_t phase;

   assign wr_en = aw_got && w_got && !bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wa <= 8'h00;
         wd <= 32'h0;
         ws <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_got <= 1'b1;
            wa <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_got <= 1'b1;
            wd <= wdata;
            ws <= wstrb;
            wready <= 1'b0;
         end
         if (wr_en)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid <= 1'b1;
            bresp <= aoc_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg <= CFG_RST;
         off_lim <= OFF_LIM_RST;
         cnt_lim <= CNT_LIM_RST;
      end
      else if (wr_en)
      begin
         if (wa == A_CFG)
            cfg <= 5'(aoc_merge(32'(cfg), wd, ws));
         if (wa == A_OFF_LIM)
            off_lim <= 26'(aoc_merge(32'(off_lim), wd, ws));
         if (wa == A_CNT_LIM)
            cnt_lim <= 8'(aoc_merge(32'(cnt_lim), wd, ws));
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= aoc_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            A_CFG: rdata <= 32'(cfg);
            // [R12] flag shown in both
            A_ACCEL_STAT, A_DEV_STAT:
               rdata <= {30'h0, offset_init_done, offset_error};
            A_DATA_HI: rdata <= {24'h0, data16[15:8]};
            A_DATA_LO: rdata <= {24'h0, data16[7:0]};
            A_OFF_LIM: rdata <= 32'(off_lim);
            A_CNT_LIM: rdata <= 32'(cnt_lim);
            default: rdata <= 32'h0;
         endcase
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // startup phases and monitor start
   // ------------------------------------------------------------
   logic [26:0] boot_cnt;
   logic mon_en;

   // [R4] phase timing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         boot_cnt <= 27'h0;
         phase <= PH_ONE;
         mon_en <= 1'b0;
         offset_init_done <= 1'b0;
      end
      else
      begin
         // [R8] timers ignore self-test
         if (boot_cnt != MON_CYC)
            boot_cnt <= boot_cnt + 27'h1;
         // [R10] monitor start
         mon_en <= boot_cnt >= MON_CYC - 27'h1;
         case (phase)
            PH_ONE:
               if (boot_cnt >= PH1_CYC - 27'h1)
                  phase <= PH_TWO;
            PH_TWO:
               if (boot_cnt >= PH1_CYC + PH2_CYC - 27'h1)
               begin
                  phase <= PH_DONE;
                  offset_init_done <= 1'b1;
               end
            PH_DONE: phase <= PH_DONE;
            default: phase <= PH_ONE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // offset low-pass filter
   // ------------------------------------------------------------
   logic signed [25:0] x_prev;
   logic signed [SW-1:0] yst;
   logic signed [SW-1:0] next_y;
   logic signed [81:0] prod_c;
   logic signed [52:0] prod_b;
   logic [24:0] coef_c, coef_b;
   logic [1:0] eff;
   logic signed [25:0] filt;

   assign filt = yst[SW-1:FB];

   // [R3] coefficient choice
   always_comb
   begin
      case (phase)
         PH_ONE: eff = FSEL_10;
         PH_TWO: eff = FSEL_1;
         default: eff = cfg[1:0];
      endcase
      case (eff)
         FSEL_10:
         begin
            coef_c = C_10;
            coef_b = B_10;
         end
         FSEL_1:
         begin
            coef_c = C_1;
            coef_b = B_1;
         end
         default:
         begin
            coef_c = C_01;
            coef_b = B_01;
         end
      endcase
      // [R2] y = y1 - c*y1 + b*(x + x1)
      prod_c = yst * $signed({1'b0, coef_c});
      prod_b = (sample_in + x_prev) * $signed({1'b0, coef_b});
      next_y = yst - SW'(prod_c >>> FB) + SW'(prod_b);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         x_prev <= 26'sh0;
         yst <= '0;
      end
      else if (sample_valid)
      begin
         x_prev <= sample_in;
         yst <= next_y;
      end
   end

   // ------------------------------------------------------------
   // cancellation output with rate limit
   // ------------------------------------------------------------
   logic signed [25:0] oc_out;
   logic [26:0] slew_cnt;
   logic slew_tick;
   logic signed [26:0] oc_diff;

   assign oc_diff = 27'(filt) - 27'(oc_out);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slew_cnt <= 27'h0;
         slew_tick <= 1'b0;
      end
      else
      begin
         slew_tick <= slew_cnt == SLEW_CYC - 27'h1;
         slew_cnt <= (slew_cnt == SLEW_CYC - 27'h1) ? 27'h0 :
            slew_cnt + 27'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         oc_out <= 26'sh0;
      // [R8] frozen in self-test
      else if (cfg[CFG_ST_BIT])
         oc_out <= oc_out;
      // [R4] startup unlimited
      else if (phase != PH_DONE)
         oc_out <= filt;
      // [R5] select field off
      else if (cfg[1:0] == FSEL_OFF)
         oc_out <= 26'sh0;
      // [R6] limit enable
      else if (!cfg[CFG_RL_BIT])
         oc_out <= filt;
      // [R7] one step per period
      else if (slew_tick)
      begin
         if (oc_diff > OFF_STEP)
            oc_out <= 26'(27'(oc_out) + OFF_STEP);
         else if (oc_diff < -OFF_STEP)
            oc_out <= 26'(27'(oc_out) - OFF_STEP);
         else
            oc_out <= filt;
      end
   end

   // ------------------------------------------------------------
   // offset monitor
   // ------------------------------------------------------------
   logic [7:0] mon_cnt;
   logic [25:0] filt_mag;
   logic out_lim;
   logic err_clr;

   assign filt_mag = filt[25] ? 26'(-filt) : 26'(filt);
   assign out_lim = filt_mag > off_lim;
   assign err_clr = wr_en && wa == A_ACCEL_STAT && ws[0] && wd[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mon_cnt <= 8'h0;
      // [R21] idle until enabled
      else if (!mon_en)
         mon_cnt <= 8'h0;
      else if (sample_valid)
      begin
         // [R11] [R13] saturating up/down
         if (out_lim && mon_cnt != MON_MAX)
            mon_cnt <= mon_cnt + 8'h1;
         else if (!out_lim && mon_cnt != 8'h0)
            mon_cnt <= mon_cnt - 8'h1;
      end
   end

   // a clear in the same cycle as a set loses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         offset_error <= 1'b0;
      else if (!mon_en)
         offset_error <= 1'b0;
      // [R12] sticky error
      else if (mon_cnt > cnt_lim)
         offset_error <= 1'b1;
      else if (err_clr)
         offset_error <= 1'b0;
   end

   // ------------------------------------------------------------
   // delay, interpolation and output words
   // ------------------------------------------------------------
   logic signed [26:0] cur, prev;
   logic [5:0] us_cyc;
   logic [3:0] us_idx;
   logic signed [32:0] interp;

   // [R15] previous to current
   always_comb
      interp = 33'(prev) + ((33'(cur) - 33'(prev)) *
         $signed({1'b0, us_idx}) >>> 4);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur <= 27'sh0;
         prev <= 27'sh0;
         data16 <= 16'h0;
      end
      else if (sample_valid)
      begin
         // [R1] [R15] corrected, delayed one sample
         prev <= cur;
         cur <= 27'(sample_in) - 27'(oc_out);
         // [R18] [R20] full range for registers
         data16 <= aoc_clip(33'(cur), 2'h2);
      end
   end

   // [R14] microsecond index
   always_ff @(posedge aclk)
   begin
      if (!aresetn || sample_valid)
      begin
         us_cyc <= 6'h0;
         us_idx <= 4'h0;
      end
      else if (us_cyc == US_CYC - 6'h1)
      begin
         us_cyc <= 6'h0;
         if (us_idx != 4'hf)
            us_idx <= us_idx + 4'h1;
      end
      else
         us_cyc <= us_cyc + 6'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pdcm_word <= 16'h0;
         pdcm_valid <= 1'b0;
      end
      else
      begin
         pdcm_valid <= pdcm_cmd;
         // [R16] [R17] [R19] [R22] clipped word
         if (pdcm_cmd)
            pdcm_word <= aoc_clip(interp, {1'b0, cfg[CFG_W14_BIT]});
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_ready;
      aw_got && w_got && !bvalid;
   endsequence
   sequence s_limit_active;
      phase == PH_DONE && cfg[CFG_RL_BIT] && cfg[1:0] != FSEL_OFF &&
         !cfg[CFG_ST_BIT];
   endsequence

   AST_SELFTEST_HOLD: assert property ( // [R8]
      cfg[CFG_ST_BIT] |=> oc_out == $past(oc_out))
      else $error("offset output moved during self-test");
   AST_PH2_TIME: assert property ( // [R4]
      $rose(phase == PH_TWO) |-> boot_cnt == PH1_CYC)
      else $error("phase two entered at wrong time");
   AST_PH_ORDER: assert property ( // [R4]
      phase == PH_ONE ##1 phase != PH_ONE |-> phase == PH_TWO)
      else $error("startup phases out of order");
   AST_MON_IDLE: assert property ( // [R21]
      !mon_en |-> mon_cnt == 8'h0 && !offset_error)
      else $error("monitor active before start");
   AST_MON_START: assert property ( // [R10]
      $rose(mon_en) |-> boot_cnt == MON_CYC)
      else $error("monitor started at wrong time");
   AST_CNT_SAT: assert property ( // [R13]
      mon_en && sample_valid && out_lim && mon_cnt == MON_MAX
      |=> mon_cnt == MON_MAX)
      else $error("monitor counter wrapped");
   AST_ERR_SET: assert property ( // [R12]
      mon_en && mon_cnt > cnt_lim |=> offset_error)
      else $error("offset error not set");
   AST_RATE: assert property ( // [R7]
      s_limit_active |=> oc_out - $past(oc_out) <= OFF_STEP &&
         $past(oc_out) - oc_out <= OFF_STEP)
      else $error("rate limit exceeded");
   AST_INTERP_PREV: assert property ( // [R15]
      sample_valid |=> prev == $past(cur))
      else $error("previous sample not kept");
   AST_PDCM_WORD: assert property ( // [R16]
      pdcm_cmd |=> pdcm_valid &&
         pdcm_word == aoc_clip($past(interp), {1'b0, $past(cfg[3])}))
      else $error("periodic word wrong");
   AST_CLIP10: assert property ( // [R22]
      pdcm_valid && !cfg[CFG_W14_BIT] && !$past(cfg[CFG_W14_BIT]) |->
         $signed(pdcm_word) <= 16'sh01ff &&
         $signed(pdcm_word) >= -16'sh01ff)
      else $error("10-bit word out of range");
   AST_BRESP: assert property (
      s_wr_ready |=> bvalid ##0 !awready && !wready)
      else $error("write response missing");
endmodule : aoc_top
`default_nettype wire

// *** hw/aoc_pkg.sv ***
// Behaviour
// [R1] optional offset cancellation subtracts estimated offset from signal
// [R2] offset estimate comes from a first-order IIR low-pass filter
// [R3] three offset filter sets: 10 Hz, 1.0 Hz and 0.1 Hz
// [R4] startup runs 10 Hz for 80 ms, then 1.0 Hz for 70 ms, unlimited
// [R5] after startup the offset filter select field picks the filter
// [R6] the same select field enables output rate limiting after startup; the code uses a separate cfg bit (CFG_RL_BIT) instead
// [R7] rate limited output moves at most one step per slew period
// [R8] self-test freezes the cancellation output; startup timers keep running
// [R9] host should see offset init done before starting self-test
// [R10] offset monitor starts 2.1 s after reset regardless of select field
// [R11] monitor counter goes up outside limits, down inside them
// [R12] counter above count limit sets offset error in both status registers
// [R13] monitor counter saturates at its maximum, never wraps
// [R14] 16 to 1 linear interpolation gives 1 us output resolution
// [R15] each result is delayed one sample; interpolate previous to current
// [R16] periodic command sends interpolated sample, one sample latency
// [R17] 26-bit result is clipped and scaled to 10, 14 or 16 bits
// [R18] 10/14-bit word goes to periodic mode; 16-bit to data registers
// [R19] all widths share one LSB weight; 14-bit adds four range bits
// [R20] 16-bit register data adds six range bits, for test use
// [R21] before monitor start, counter stays zero and error flag clear
// [R22] out-of-range values saturate to the extreme valid code
`default_nettype none
package aoc_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int T_PH1_MS = 80;
   localparam int T_PH2_MS = 70;
   localparam int T_MON_MS = 2100;
   localparam int T_US_NS = 1000;
   localparam int T_SLEW_US = 1000;
   localparam int PH1_CYC_D = T_PH1_MS * (CLK_HZ / 1000);
   localparam int PH2_CYC_D = T_PH2_MS * (CLK_HZ / 1000);
   localparam int MON_CYC_D = T_MON_MS * (CLK_HZ / 1000);
   localparam int SLEW_CYC_D = T_SLEW_US * (CLK_HZ / 1_000_000);
   localparam logic [5:0] US_CYC = 6'(T_US_NS / CLK_NS);
   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   localparam int DW = 26;
   localparam int FB = 30;
   localparam int SW = DW + FB;
   localparam int SCALE_SH = 10;
   localparam logic signed [26:0] OFF_STEP = 27'sh0000001;
   // feedback term (1 + d2) and feed-forward a0*n, both scaled by 2^30
   localparam logic [24:0] C_10 = 25'h1057041;
   localparam logic [24:0] B_10 = 25'h082b800;
   localparam logic [24:0] C_1 = 25'h01a5500;
   localparam logic [24:0] B_1 = 25'h00d2a8c;
   localparam logic [24:0] C_01 = 25'h002a2c0;
   localparam logic [24:0] B_01 = 25'h0015140;
   localparam logic [1:0] FSEL_OFF = 2'h0;
   localparam logic [1:0] FSEL_10 = 2'h1;
   localparam logic [1:0] FSEL_1 = 2'h2;
   localparam int CFG_RL_BIT = 2;
   localparam int CFG_W14_BIT = 3;
   localparam int CFG_ST_BIT = 4;
   localparam logic signed [32:0] MAX10 = 33'sh0000001ff;
   localparam logic signed [32:0] MAX14 = 33'sh000001fff;
   localparam logic signed [32:0] MAX16 = 33'sh000007fff;
   localparam logic [7:0] MON_MAX = 8'hff;
   // ------------------------------------------------------------
   // register map and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_ACCEL_STAT = 8'h04;
   localparam logic [7:0] A_DEV_STAT = 8'h08;
   localparam logic [7:0] A_DATA_HI = 8'h0c;
   localparam logic [7:0] A_DATA_LO = 8'h10;
   localparam logic [7:0] A_OFF_LIM = 8'h14;
   localparam logic [7:0] A_CNT_LIM = 8'h18;
   localparam logic [4:0] CFG_RST = 5'h03;
   localparam logic [25:0] OFF_LIM_RST = 26'h0100000;
   localparam logic [7:0] CNT_LIM_RST = 8'h80;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      PH_ONE = 2'b00,
      PH_TWO = 2'b01,
      PH_DONE = 2'b10
   } aoc_phase_t;
endpackage : aoc_pkg
`default_nettype wire

// *** verification/aoc_dsi_master.sv ***
`default_nettype none
module aoc_dsi_master
   import aoc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] pdcm_word,
   input wire logic pdcm_valid,
   output var logic pdcm_cmd,
   output var logic [15:0] got_word,
   output var logic got
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pdcm_cmd = 1'b0;
   // ------------------------------------------------------------
   // command and capture
   // ------------------------------------------------------------
   task automatic send_cmd();
      @(posedge aclk);
      pdcm_cmd <= 1'b1;
      @(posedge aclk);
      pdcm_cmd <= 1'b0;
   endtask : send_cmd
   // word lands one cycle after the command edge
   always @(posedge aclk)
   begin
      got <= aresetn && pdcm_valid === 1'b1;
      got_word <= pdcm_word;
   end
endmodule : aoc_dsi_master
`default_nettype wire

// *** verification/tb_top.sv ***
`default_nettype none
module tb_top
   import aoc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, sample_valid = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic signed [25:0] sample_in = 26'sh0;
   logic awready, wready, bvalid, arready, rvalid, got;
   logic pdcm_cmd, pdcm_valid, offset_error, offset_init_done;
   logic [1:0] bresp, rresp;
   logic [15:0] pdcm_word, got_word;
   int num_errors = 0;
   int compares = 0;
   logic [33:0] q_bus[$];
   logic [15:0] q_pd[$];
   always #10 aclk = ~aclk;
   aoc_top #(.PH1_CYC(27'd40), .PH2_CYC(27'd35), .MON_CYC(27'd200),
      .SLEW_CYC(27'd8)) aoc_top_i (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .sample_in, .sample_valid, .pdcm_cmd, .pdcm_word,
      .pdcm_valid, .offset_error, .offset_init_done);
   aoc_dsi_master dsi_i (.aclk, .aresetn, .pdcm_word, .pdcm_valid,
      .pdcm_cmd, .got_word, .got);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic fail(input string s);
      $display("[FAIL] %0t %s", $time, s);
      num_errors++;
   endtask : fail
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 2000)
      begin
         fail("wait timed out");
         give_verdict();
      end
   endtask : tick
   function automatic logic [15:0] clipw(input logic signed [25:0] v,
      input int m);
      int x;
      x = int'(v >>> 10);
      if (x > m)
         x = m;
      if (x < -m)
         x = -m;
      return 16'(x);
   endfunction : clipw
   // ------------------------------------------------------------
   // register bus master
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int n;
      logic aw;
      logic w;
      n = 0;
      aw = 1'b0;
      w = 1'b0;
      q_bus.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w))
      begin
         tick(n);
         if (awready === 1'b1 && !aw)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1)
         tick(n);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      q_bus.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (arready !== 1'b1 || n == 0)
         tick(n);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         tick(n);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic smp(input logic [25:0] v, input int gap);
      sample_in <= v;
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      repeat (gap) @(posedge aclk);
   endtask : smp
   // ------------------------------------------------------------
   // result monitor
   // ------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (bvalid === 1'b1 && bready === 1'b1 && q_bus.size() > 0)
      begin
         compares++;
         if ({bresp, 32'h0} !== q_bus.pop_front())
            fail("write response");
      end
      if (rvalid === 1'b1 && rready === 1'b1 && q_bus.size() > 0)
      begin
         compares++;
         if ({rresp, rdata} !== q_bus.pop_front())
            fail("read data");
      end
      if (got === 1'b1)
      begin
         compares++;
         if (q_pd.size() == 0)
            fail("unexpected word");
         else if (got_word !== q_pd.pop_front())
            fail("periodic word");
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      int n;
      logic [25:0] v;
      logic [15:0] e16;
      void'($urandom(32'hd34a));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      n = 0;
      while (offset_init_done !== 1'b1)
         tick(n);
      compares += 2;
      if (n < 72 || n > 80)
         fail("startup length");
      if (offset_error !== 1'b0)
         fail("early offset error");
      rd(A_CFG, {RESP_OKAY, 27'h0, CFG_RST});
      rd(A_OFF_LIM, {RESP_OKAY, 6'h0, OFF_LIM_RST});
      rd(A_CNT_LIM, {RESP_OKAY, 24'h0, CNT_LIM_RST});
      rd(A_ACCEL_STAT, {RESP_OKAY, 32'h2});
      rd(8'hfc, {RESP_SLVERR, 32'h0});
      wr(8'hfc, 32'h0, RESP_SLVERR);
      // extremes, then wide and in-range random values, both widths
      for (int i = 0; i < 8; i++)
      begin
         case (i[2:1])
            2'd0: v = 26'h1ffffff;
            2'd1: v = 26'h2000000;
            2'd2: v = 26'($urandom);
            default: v = 26'($urandom_range(0, 32'h7ffff)) - 26'h40000;
         endcase
         wr(A_CFG, i[0] ? 32'h8 : 32'h0, RESP_OKAY);
         smp(v, 800);
         smp(v, 100);
         q_pd.push_back(clipw(v, i[0] ? 8191 : 511));
         dsi_i.send_cmd();
         e16 = clipw(v, 32767);
         rd(A_DATA_HI, {RESP_OKAY, 24'h0, e16[15:8]});
         rd(A_DATA_LO, {RESP_OKAY, 24'h0, e16[7:0]});
         repeat (600) @(posedge aclk);
      end
      // previous 0, current 16 words: each us adds one word
      smp(26'h0, 800);
      smp(26'h4000, 1);
      repeat (21) @(posedge aclk);
      for (int k = 0; k < 18; k++)
      begin
         q_pd.push_back(16'(k > 15 ? 15 : k));
         dsi_i.send_cmd();
         repeat (48) @(posedge aclk);
      end
      wr(A_OFF_LIM, 32'h0, RESP_OKAY);
      wr(A_CNT_LIM, 32'h2, RESP_OKAY);
      smp(26'h1000000, 800);
      smp(26'h1000000, 800);
      compares++;
      if (offset_error !== 1'b0)
         fail("offset error too soon");
      repeat (2) smp(26'h1000000, 800);
      compares++;
      if (offset_error !== 1'b1)
         fail("offset error missing");
      wr(A_DEV_STAT, 32'h0, RESP_OKAY);
      // clear request while the counter is still above its limit
      wr(A_ACCEL_STAT, 32'h1, RESP_OKAY);
      rd(A_ACCEL_STAT, {RESP_OKAY, 32'h3});
      rd(A_DEV_STAT, {RESP_OKAY, 32'h3});
      // self-test holds cancellation at zero, then a rate limited release
      for (int j = 0; j < 2; j++)
      begin
         v = 26'h0400200 + 26'($urandom_range(0, 255) * 1024);
         // init done was seen before self-test
         wr(A_CFG, j ? 32'hd : 32'h19, RESP_OKAY);
         smp(v, 40);
         smp(v, 800);
         q_pd.push_back(clipw(v, 8191));
         dsi_i.send_cmd();
      end
      repeat (5) @(posedge aclk);
      compares++;
      if (q_pd.size() != 0 || q_bus.size() != 0)
         fail("result missing");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
